// >>> rtl/epo_regs.svh
// Register offsets, object identifiers, codes, reset values and timing for the pulse output port.
`ifndef EPO_REGS_SVH
`define EPO_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// Modbus register offsets, register number minus 40001.
`define EPO_OFS_MANUAL 16'h1131
`define EPO_OFS_CONFIG 16'h13F5
`define EPO_OFS_RELAY 16'h13F6
`define EPO_OFS_SCALAR 16'h11F9

////////////////////////////////////////////////////////////////////////////////
// BACnet object identifiers 13020, 13100 and 13110.
`define EPO_OBJ_MANUAL 16'h32DC
`define EPO_OBJ_CONFIG 16'h332C
`define EPO_OBJ_RELAY 16'h3336

////////////////////////////////////////////////////////////////////////////////
// Port configuration codes 0, 44001, 44008 and 44011.
`define EPO_CFG_OFF 16'h0000
`define EPO_CFG_REAL 16'hABE1
`define EPO_CFG_REACT 16'hABE8
`define EPO_CFG_APPAR 16'hABEB

////////////////////////////////////////////////////////////////////////////////
// Reset values.
`define EPO_RST_MANUAL 16'h0001
`define EPO_RST_CONFIG 16'h0000
`define EPO_RST_RELAY 16'h0000
`define EPO_RST_SCALAR 16'h0004

////////////////////////////////////////////////////////////////////////////////
// Pulse weights in accumulator units of .00001, for data scalar 0 to 6 and above.
`define EPO_WEIGHT_0 48'h0000_0000_0001
`define EPO_WEIGHT_1 48'h0000_0000_0064
`define EPO_WEIGHT_2 48'h0000_0000_03E8
`define EPO_WEIGHT_3 48'h0000_0000_2710
`define EPO_WEIGHT_4 48'h0000_0001_86A0
`define EPO_WEIGHT_5 48'h0000_000F_4240
`define EPO_WEIGHT_6 48'h0000_0098_9680

////////////////////////////////////////////////////////////////////////////////
// Pulse active time and the least idle gap that follows it.
`define EPO_CLK_PERIOD_NS 5
`define EPO_PULSE_TIME_NS 10000
`define EPO_PULSE_CYCLES ((`EPO_PULSE_TIME_NS + `EPO_CLK_PERIOD_NS - 1) / `EPO_CLK_PERIOD_NS)

`endif

// >>> rtl/epo_pkg.sv
// Types shared by the pulse output port modules.
package epo_pkg;

   typedef enum logic [1:0] {
      SRC_NONE = 2'b00,
      SRC_REAL = 2'b01,
      SRC_REACT = 2'b10,
      SRC_APPAR = 2'b11
   } epo_src_t;

   typedef enum logic [1:0] {
      GEN_IDLE = 2'b00,
      GEN_ACTIVE = 2'b01,
      GEN_GAP = 2'b10
   } epo_gen_state_t;

   typedef enum logic [2:0] {
      REG_NONE = 3'b000,
      REG_MANUAL = 3'b001,
      REG_CONFIG = 3'b010,
      REG_RELAY = 3'b011,
      REG_SCALAR = 3'b100
   } epo_reg_t;

   // Accumulated system energies, unsigned, in units of .00001.
   typedef struct packed {
      logic [47:0] activeE;
      logic [47:0] reactiveE;
      logic [47:0] apparentE;
   } epo_energy_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic obj;
      logic [15:0] addr;
      logic [15:0] wdata;
   } epo_reg_req_t;

   typedef struct packed {
      logic ack;
      logic err;
      logic [15:0] rdata;
   } epo_reg_resp_t;

   typedef struct packed {
      epo_gen_state_t state;
      epo_src_t srcPrev;
      logic [47:0] baseline;
      logic [11:0] count;
   } epo_gen_t;

   typedef struct packed {
      logic [15:0] manual;
      logic [15:0] portCfg;
      logic [15:0] relay;
      logic [15:0] scalar;
      epo_reg_resp_t resp;
      logic pinOut;
      logic ledOn;
   } epo_top_t;

endpackage

// >>> rtl/epo_pulse_gen.sv
// Pulse generator: counts weight-sized steps of the selected energy and times each pulse.
`timescale 1ns/1ps
`include "epo_regs.svh"

module epo_pulse_gen (
   input wire logic clk,
   input wire logic rst,
   input wire epo_pkg::epo_src_t src,
   input wire logic [15:0] scalar,
   input wire epo_pkg::epo_energy_t energy,
   output logic pulseActive
);

   localparam logic [11:0] PULSE_LAST = 12'(`EPO_PULSE_CYCLES - 1);

   epo_pkg::epo_gen_t s_r;
   epo_pkg::epo_gen_t s_nxt;
   logic [47:0] sel;
   logic [47:0] weight;
   logic [47:0] diff;

   function automatic logic [47:0] scalarWeight(input logic [15:0] sc);
      logic [47:0] w;
      w = `EPO_WEIGHT_6;
      unique case (sc)
         16'h0000: w = `EPO_WEIGHT_0;
         16'h0001: w = `EPO_WEIGHT_1;
         16'h0002: w = `EPO_WEIGHT_2;
         16'h0003: w = `EPO_WEIGHT_3;
         16'h0004: w = `EPO_WEIGHT_4;
         16'h0005: w = `EPO_WEIGHT_5;
         default: w = `EPO_WEIGHT_6;
      endcase
      return w;
   endfunction

   always_comb begin
      unique case (src)
         epo_pkg::SRC_REAL: sel = energy.activeE;
         epo_pkg::SRC_REACT: sel = energy.reactiveE;
         epo_pkg::SRC_APPAR: sel = energy.apparentE;
         epo_pkg::SRC_NONE: sel = 48'h0;
      endcase
   end

   // One weight serves every source.
   assign weight = scalarWeight(scalar);
   assign diff = sel - s_r.baseline;

   always_comb begin
      s_nxt = s_r;
      s_nxt.srcPrev = src;
      // A new source, a disabled port or an accumulator that went backwards restarts counting.
      if (src != s_r.srcPrev || src == epo_pkg::SRC_NONE || sel < s_r.baseline) begin
         s_nxt.baseline = sel;
         s_nxt.state = epo_pkg::GEN_IDLE;
         s_nxt.count = 12'h000;
      end else begin
         unique case (s_r.state)
            epo_pkg::GEN_IDLE: begin
               if (diff >= weight) begin
                  // Only one weight is consumed, so any excess is kept for later pulses.
                  s_nxt.baseline = s_r.baseline + weight;
                  s_nxt.state = epo_pkg::GEN_ACTIVE;
                  s_nxt.count = PULSE_LAST;
               end
            end
            epo_pkg::GEN_ACTIVE: begin
               if (s_r.count == 12'h000) begin
                  s_nxt.state = epo_pkg::GEN_GAP;
                  s_nxt.count = PULSE_LAST;
               end else begin
                  s_nxt.count = s_r.count - 12'h001;
               end
            end
            epo_pkg::GEN_GAP: begin
               if (s_r.count == 12'h000) begin
                  s_nxt.state = epo_pkg::GEN_IDLE;
               end else begin
                  s_nxt.count = s_r.count - 12'h001;
               end
            end
            default: begin
               s_nxt.state = epo_pkg::GEN_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '{state: epo_pkg::GEN_IDLE, srcPrev: epo_pkg::SRC_NONE,
                  baseline: 48'h0, count: 12'h000};
      end else begin
         s_r <= s_nxt;
      end
   end

   // Fixed-length active phase.
   assign pulseActive = (s_r.state == epo_pkg::GEN_ACTIVE);

endmodule

// >>> rtl/epo_pulse_port.sv
// Energy pulse output port: settings registers, source selection and port level.
//
// Functional notes
// - Configuration value picks off, real, reactive, apparent.
// - Data scalar maps to weight .00001 up to 100.
// - One scalar weights all sources, Modbus only.
// - One pulse per weight of selected energy.
// - LED lit only during output pulse.
// - Manual 0 drives low, 1 high, default high.
// - Manual value applies only with configuration zero.
// - Relay type sets idle level: 0 high, 1 low.
// - Manual, configuration and relay settings reachable as BACnet objects; scalar by Modbus only.
`timescale 1ns/1ps
`include "epo_regs.svh"

module epo_pulse_port (
   input wire logic clk,
   input wire logic rst,
   input wire epo_pkg::epo_reg_req_t regReq,
   output epo_pkg::epo_reg_resp_t regResp,
   input wire epo_pkg::epo_energy_t energy,
   output logic pinOut,
   output logic pulseLed
);

   epo_pkg::epo_top_t s_r;
   epo_pkg::epo_top_t s_nxt;
   epo_pkg::epo_src_t src;
   epo_pkg::epo_reg_t regSel;
   logic pulseActive;
   logic idleLevel;

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode. Modbus offsets and BACnet objects land on the same storage, so a
   // setting written through one protocol is seen through the other. The data scalar
   // has no object of its own here and is reached by its Modbus offset only.
   function automatic epo_pkg::epo_reg_t decodeAddr(input logic obj, input logic [15:0] addr);
      epo_pkg::epo_reg_t r;
      r = epo_pkg::REG_NONE;
      if (obj) begin
         unique case (addr)
            `EPO_OBJ_MANUAL: r = epo_pkg::REG_MANUAL;
            `EPO_OBJ_CONFIG: r = epo_pkg::REG_CONFIG;
            `EPO_OBJ_RELAY: r = epo_pkg::REG_RELAY;
            default: r = epo_pkg::REG_NONE;
         endcase
      end else begin
         unique case (addr)
            `EPO_OFS_MANUAL: r = epo_pkg::REG_MANUAL;
            `EPO_OFS_CONFIG: r = epo_pkg::REG_CONFIG;
            `EPO_OFS_RELAY: r = epo_pkg::REG_RELAY;
            `EPO_OFS_SCALAR: r = epo_pkg::REG_SCALAR;
            default: r = epo_pkg::REG_NONE;
         endcase
      end
      return r;
   endfunction

   assign regSel = decodeAddr(regReq.obj, regReq.addr);

   ////////////////////////////////////////////////////////////////////////////////
   // Source selection. Any nonzero code other than the three listed ones sends no pulses and
   // leaves the port at its idle level; the manual value still does not apply.
   always_comb begin
      unique case (s_r.portCfg)
         `EPO_CFG_REAL: src = epo_pkg::SRC_REAL;
         `EPO_CFG_REACT: src = epo_pkg::SRC_REACT;
         `EPO_CFG_APPAR: src = epo_pkg::SRC_APPAR;
         default: src = epo_pkg::SRC_NONE;
      endcase
   end

   epo_pulse_gen u_gen (
      .clk(clk),
      .rst(rst),
      .src(src),
      .scalar(s_r.scalar),
      .energy(energy),
      .pulseActive(pulseActive)
   );

   // Normally open rests high, normally closed rests low.
   assign idleLevel = (s_r.relay[0] == 1'b0);

   ////////////////////////////////////////////////////////////////////////////////
   // Next state: register access, port level and indicator.
   always_comb begin
      s_nxt = s_r;
      s_nxt.resp.ack = regReq.wr | regReq.rd;
      s_nxt.resp.err = (regReq.wr | regReq.rd) && (regSel == epo_pkg::REG_NONE);
      s_nxt.resp.rdata = 16'h0000;
      if (regReq.wr) begin
         unique case (regSel)
            epo_pkg::REG_MANUAL: s_nxt.manual = regReq.wdata;
            epo_pkg::REG_CONFIG: s_nxt.portCfg = regReq.wdata;
            epo_pkg::REG_RELAY: s_nxt.relay = regReq.wdata;
            epo_pkg::REG_SCALAR: s_nxt.scalar = regReq.wdata;
            epo_pkg::REG_NONE: s_nxt.manual = s_r.manual;
         endcase
      end else if (regReq.rd) begin
         unique case (regSel)
            epo_pkg::REG_MANUAL: s_nxt.resp.rdata = s_r.manual;
            epo_pkg::REG_CONFIG: s_nxt.resp.rdata = s_r.portCfg;
            epo_pkg::REG_RELAY: s_nxt.resp.rdata = s_r.relay;
            epo_pkg::REG_SCALAR: s_nxt.resp.rdata = s_r.scalar;
            epo_pkg::REG_NONE: s_nxt.resp.rdata = 16'h0000;
         endcase
      end

      if (s_r.portCfg == `EPO_CFG_OFF) begin
         // Switch mode: zero closes the port, any other value opens it.
         s_nxt.pinOut = (s_r.manual != 16'h0000);
         s_nxt.ledOn = 1'b0;
      end else begin
         // Pulse mode ignores the manual value.
         s_nxt.pinOut = pulseActive ? ~idleLevel : idleLevel;
         s_nxt.ledOn = pulseActive;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '{manual: `EPO_RST_MANUAL,
                  portCfg: `EPO_RST_CONFIG,
                  relay: `EPO_RST_RELAY,
                  scalar: `EPO_RST_SCALAR,
                  resp: '{ack: 1'b0, err: 1'b0, rdata: 16'h0000},
                  pinOut: 1'b1,
                  ledOn: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign regResp = s_r.resp;
   assign pinOut = s_r.pinOut;
   assign pulseLed = s_r.ledOn;

endmodule

// >>> tb/epo_pulse_port_asserts.sv
// Concurrent checks on the pulse output port pins.
`timescale 1ns/1ps
`include "epo_regs.svh"
module epo_pulse_port_asserts (
   input wire logic clk,
   input wire logic rst,
   input wire epo_pkg::epo_reg_req_t regReq,
   input wire epo_pkg::epo_reg_resp_t regResp,
   input wire epo_pkg::epo_energy_t energy,
   input wire logic pinOut,
   input wire logic pulseLed
);
   logic [11:0] onCnt_r;
   logic [11:0] gapCnt_r;
   // The gap count starts saturated so the first pulse after reset is legal.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         onCnt_r <= 12'h000;
         gapCnt_r <= 12'hFFF;
      end else begin
         onCnt_r <= pulseLed ? onCnt_r + 12'h001 : 12'h000;
         gapCnt_r <= pulseLed ? 12'h000 : gapCnt_r + {11'h000, gapCnt_r != 12'hFFF};
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_ack_after_req: assert property (regReq.wr || regReq.rd |=> regResp.ack)
      else $error("ack missing");
   a_no_stray_ack: assert property (!(regReq.wr || regReq.rd) |=> !regResp.ack)
      else $error("stray ack");
   a_idle_rdata: assert property (!regResp.ack |-> regResp.rdata == 16'h0000)
      else $error("rdata without ack");
   a_scalar_no_obj: assert property (regReq.rd && !regReq.wr && regReq.obj &&
      regReq.addr == `EPO_OFS_SCALAR |=> regResp.err) else $error("scalar object");
   a_led_moves_pin: assert property ($rose(pulseLed) |-> $changed(pinOut))
      else $error("led without pulse");
   a_pin_held: assert property (pulseLed && $past(pulseLed) |-> $stable(pinOut))
      else $error("pin moved in pulse");
   a_pulse_width: assert property ($fell(pulseLed) |-> onCnt_r == 12'h7D0)
      else $error("pulse width");
   a_gap_width: assert property ($rose(pulseLed) |-> gapCnt_r >= 12'h7D0)
      else $error("gap too short");
   c_pulse: cover property ($fell(pulseLed));
   c_err: cover property (regResp.err);
   c_close: cover property ($rose(pulseLed) && gapCnt_r < 12'h900);
endmodule
bind epo_pulse_port epo_pulse_port_asserts chk (.clk(clk), .rst(rst), .regReq(regReq),
   .regResp(regResp), .energy(energy), .pinOut(pinOut), .pulseLed(pulseLed));

// >>> tb/epo_pulse_logger.sv
// Pulse counting logger on the far side of the port.
`timescale 1ns/1ps
module epo_pulse_logger (
   input wire logic clk,
   input wire logic rst,
   input wire logic pinOut,
   input wire logic idleLow,
   output logic [15:0] pulses
);
   logic act_r;
   wire logic act = pinOut ^ !idleLow;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         act_r <= 1'b0;
         pulses <= 16'h0000;
      end else begin
         act_r <= act;
         pulses <= pulses + {15'h0000, act && !act_r};
      end
   end
endmodule

// >>> tb/epo_pulse_port_test.sv
// Self-checking bench for the energy pulse output port.
`timescale 1ns/1ps
`include "epo_regs.svh"
module epo_pulse_port_test;
   logic clk, rst, pinOut, pulseLed, idleLow;
   epo_pkg::epo_reg_req_t regReq;
   epo_pkg::epo_reg_resp_t regResp;
   epo_pkg::epo_energy_t energy;
   logic [15:0] pulses, rdVal, base;
   logic [47:0] wts [7] = '{`EPO_WEIGHT_0, `EPO_WEIGHT_1, `EPO_WEIGHT_2, `EPO_WEIGHT_3,
      `EPO_WEIGHT_4, `EPO_WEIGHT_5, `EPO_WEIGHT_6};
   int nErrors = 0;
   int numChecks = 0;
   epo_pulse_port uut (.clk(clk), .rst(rst), .regReq(regReq), .regResp(regResp),
      .energy(energy), .pinOut(pinOut), .pulseLed(pulseLed));
   epo_pulse_logger logger (.clk(clk), .rst(rst), .pinOut(pinOut), .idleLow(idleLow),
      .pulses(pulses));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   ////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      numChecks++;
      if (got !== exp) begin
         nErrors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tallyAndFinish();
      if (nErrors == 0 && numChecks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic acc(input logic wr, obj, input logic [15:0] a, wd, input logic err);
      @(posedge clk);
      regReq <= '{wr, !wr, obj, a, wd};
      @(posedge clk);
      regReq <= '{1'b0, 1'b0, obj, a, wd};
      #1;
      rdVal = regResp.rdata;
      chk({14'h0000, regResp.ack, regResp.err}, {14'h0000, 1'b1, err});
   endtask
   // Output lags a write by two cycles; the logger count is rebased here.
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
      base = pulses;
   endtask
   task automatic bump(input int k, input logic [47:0] amt);
      @(posedge clk);
      if (k == 0) energy.activeE <= energy.activeE + amt;
      else if (k == 1) energy.reactiveE <= energy.reactiveE + amt;
      else energy.apparentE <= energy.apparentE + amt;
   endtask
   // A wrong extra pulse starts within a few cycles of a short bump, or one pulse and one gap later.
   task automatic xn(input logic [15:0] n);
      int i;
      int lim;
      lim = 4100 * n + 10;
      for (i = 0; i < lim && pulses !== base + n; i++) @(posedge clk);
      if (i == lim) begin
         nErrors++;
         tallyAndFinish();
      end
      repeat (n == 16'h0000 ? 20 : 4010) @(posedge clk);
      #1;
      chk(pulses, base + n);
      base = pulses;
   endtask
   ////////////////////////////////////////
   task automatic sc_reset();
      chk({14'h0000, pinOut, pulseLed}, 16'h0002);
      acc(0, 0, `EPO_OFS_MANUAL, 16'h0000, 0);
      chk(rdVal, `EPO_RST_MANUAL);
      acc(0, 0, `EPO_OFS_CONFIG, 16'h0000, 0);
      chk(rdVal, `EPO_RST_CONFIG);
      acc(0, 1, `EPO_OBJ_RELAY, 16'h0000, 0);
      chk(rdVal, `EPO_RST_RELAY);
      acc(0, 0, `EPO_OFS_SCALAR, 16'h0000, 0);
      chk(rdVal, `EPO_RST_SCALAR);
   endtask
   // Manual ends at zero so that the gating check that follows can tell it apart.
   task automatic sc_switch();
      acc(1, 1, `EPO_OBJ_MANUAL, 16'h0000, 0);
      settle();
      chk({15'h0000, pinOut}, 16'h0000);
      acc(0, 0, `EPO_OFS_MANUAL, 16'h0000, 0);
      chk(rdVal, 16'h0000);
      acc(1, 0, `EPO_OFS_MANUAL, 16'h0001, 0);
      settle();
      chk({15'h0000, pinOut}, 16'h0001);
      acc(1, 1, `EPO_OBJ_MANUAL, 16'h0000, 0);
      acc(1, 0, 16'h0000, 16'h0001, 1);
      acc(0, 1, `EPO_OFS_SCALAR, 16'h0000, 1);
      chk(rdVal, 16'h0000);
   endtask
   task automatic sc_gate();
      acc(1, 1, `EPO_OBJ_CONFIG, `EPO_CFG_REAL, 0);
      settle();
      chk({15'h0000, pinOut}, 16'h0001);
      acc(1, 1, `EPO_OBJ_RELAY, 16'h0001, 0);
      idleLow = 1'b1;
      settle();
      chk({15'h0000, pinOut}, 16'h0000);
      bump(0, wts[4]);
      repeat (4) @(posedge clk);
      #1;
      chk({14'h0000, pinOut, pulseLed}, 16'h0003);
      xn(1);
      acc(1, 0, `EPO_OFS_RELAY, 16'h0000, 0);
      idleLow = 1'b0;
   endtask
   task automatic sc_sources();
      logic [15:0] cfg [3] = '{`EPO_CFG_REAL, `EPO_CFG_REACT, `EPO_CFG_APPAR};
      acc(1, 0, `EPO_OFS_SCALAR, 16'h0000, 0);
      for (int k = 0; k < 3; k++) begin
         acc(1, 0, `EPO_OFS_CONFIG, cfg[k], 0);
         settle();
         bump((k + 1) % 3, 48'h0000_0000_0005);
         bump(k, 48'h0000_0000_0001);
         xn(1);
      end
   endtask
   // The real source is selected again, since the loop before left apparent energy on.
   task automatic sc_weights();
      acc(1, 0, `EPO_OFS_CONFIG, `EPO_CFG_REAL, 0);
      for (int s = 1; s < 8; s++) begin
         acc(1, 0, `EPO_OFS_SCALAR, 16'(s), 0);
         settle();
         bump(0, wts[s > 6 ? 6 : s] - 48'h0000_0000_0001);
         xn(0);
         bump(0, 48'h0000_0000_0001);
         xn(1);
      end
   endtask
   task automatic sc_excess_off();
      acc(1, 0, `EPO_OFS_SCALAR, 16'h0003, 0);
      settle();
      bump(0, wts[3] * 3);
      xn(3);
      acc(1, 0, `EPO_OFS_CONFIG, 16'h1234, 0);
      settle();
      bump(0, wts[3]);
      xn(0);
      chk({14'h0000, pinOut, pulseLed}, 16'h0002);
   endtask
   // A reset in mid-run must bring back every default although manual, configuration and scalar were changed.
   task automatic sc_rereset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
      sc_reset();
   endtask
   initial begin
      rst = 1'b1;
      idleLow = 1'b0;
      regReq = '0;
      energy = '0;
      base = 16'h0000;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      #1;
      sc_reset();
      sc_switch();
      sc_gate();
      sc_sources();
      sc_weights();
      sc_excess_off();
      sc_rereset();
      tallyAndFinish();
   end
endmodule
